//--- fdss_consts.svh
`ifndef FDSS_CONSTS_SVH
`define FDSS_CONSTS_SVH

// register byte addresses
`define FDSS_ADDR_SYS_CMD 8'h06
`define FDSS_ADDR_SYS_STAT 8'h07
// system state command codes
`define FDSS_CMD_READY 8'h01
`define FDSS_CMD_ACTIVE 8'h02
`define FDSS_SYS_CMD_RESET 8'h01
// spread mode encodings
`define FDSS_MODE_OFF 2'h0
`define FDSS_MODE_CENTER 2'h1
`define FDSS_MODE_INVALID 2'h2
`define FDSS_MODE_DOWN 2'h3
// field widths
`define FDSS_CLK_NUM_W 8
`define FDSS_STEP_NUM_W 12
`define FDSS_STEP_RES_W 15
`define FDSS_OFFSET_W 32

`endif

//--- fdss_pkg.sv
package fdss_pkg;
    typedef struct packed {
        logic ena;
        logic [1:0] mode;
        logic [7:0] clk_num;
        logic [11:0] step_num;
        logic [7:0] step_intg;
        logic [14:0] step_res;
        logic [14:0] step_den;
    } fdss_bank_t;

    typedef enum logic [1:0] {
        FDSS_ST_READY,
        FDSS_ST_ACTIVE
    } fdss_sys_state_t;

    typedef enum logic {
        FDSS_DIR_UP,
        FDSS_DIR_DOWN
    } fdss_dir_t;
endpackage

//--- fdss_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fdss_consts.svh"

// Overview of operation
// - bank switch changes frequency only at a step boundary, never mid-clock
// - spread offset exists only on fractional divider outputs, none on integer ones
// - each fractional divider keeps main and backup profile; one active at a time
// - enable bit alone may change live; other active bank fields are held
// - spread runs only when enabled and mode is center or down
// - quarter step count spans mean frequency to the extreme
// - command register takes 0x01 for READY and 0x02 for ACTIVE
// - four independent field groups: divider 0 or 1, bank A or B
// - fractional bank select 0 picks A, 1 picks B, at the next boundary with zero offset
// - integer bank select 0 picks divide A, 1 picks divide B
module fdss_top #(
    parameter int NUM_DIV = 2,
    parameter int INT_W = 8
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // bank field groups, index = divider*2 + bank
    input wire fdss_pkg::fdss_bank_t bank_cfg_i [2*NUM_DIV],
    input wire logic [NUM_DIV-1:0] frequency_select_i,
    input wire logic [NUM_DIV-1:0] input_clk_ok_i,
    // integer divider bank values
    input wire logic int_frequency_select_i,
    input wire logic [INT_W-1:0] int_div_a_i,
    input wire logic [INT_W-1:0] int_div_b_i,
    // divider outputs
    output logic [NUM_DIV-1:0] active_bank_o,
    output logic [NUM_DIV-1:0] spread_on_o,
    output logic [`FDSS_OFFSET_W-1:0] frac_offset_o [NUM_DIV],
    output logic [INT_W-1:0] int_div_o,
    output logic active_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_DIV-1:0] fs_meta, fs_sync, ok_meta, ok_sync;
    logic int_fs_meta, int_fs_sync;
    logic [NUM_DIV-1:0] next_fs_sync, next_ok_sync;
    logic next_int_fs_sync;

    always_comb begin
        next_fs_sync = fs_meta;
        next_ok_sync = ok_meta;
        next_int_fs_sync = int_fs_meta;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fs_meta <= '0;
            fs_sync <= '0;
            ok_meta <= '0;
            ok_sync <= '0;
            int_fs_meta <= 1'b0;
            int_fs_sync <= 1'b0;
        end else if (clk_en_i) begin
            fs_meta <= frequency_select_i;
            fs_sync <= next_fs_sync;
            ok_meta <= input_clk_ok_i;
            ok_sync <= next_ok_sync;
            int_fs_meta <= int_frequency_select_i;
            int_fs_sync <= next_int_fs_sync;
        end
    end

    // ------------------------------------------------------------
    // system state command
    // ------------------------------------------------------------
    logic [7:0] system_state_command, next_cmd;
    fdss_pkg::fdss_sys_state_t sys_state, next_sys_state;
    logic [7:0] next_rdata;
    logic next_active;

    always_comb begin
        next_cmd = system_state_command;
        next_sys_state = sys_state;
        if (reg_wr_i && reg_addr_i == `FDSS_ADDR_SYS_CMD) begin
            next_cmd = reg_wdata_i;
            if (reg_wdata_i == `FDSS_CMD_READY) begin
                next_sys_state = fdss_pkg::FDSS_ST_READY;
            end else if (reg_wdata_i == `FDSS_CMD_ACTIVE) begin
                next_sys_state = fdss_pkg::FDSS_ST_ACTIVE;
            end
        end
        case (reg_addr_i)
            `FDSS_ADDR_SYS_CMD: next_rdata = system_state_command;
            `FDSS_ADDR_SYS_STAT: next_rdata = (sys_state == fdss_pkg::FDSS_ST_ACTIVE) ?
                `FDSS_CMD_ACTIVE : `FDSS_CMD_READY;
            default: next_rdata = 8'h00;
        endcase
        next_active = (next_sys_state == fdss_pkg::FDSS_ST_ACTIVE);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            system_state_command <= `FDSS_SYS_CMD_RESET;
            sys_state <= fdss_pkg::FDSS_ST_READY;
            reg_rdata_o <= 8'h00;
            active_o <= 1'b0;
        end else if (clk_en_i) begin
            system_state_command <= next_cmd;
            sys_state <= next_sys_state;
            reg_rdata_o <= next_rdata;
            active_o <= next_active;
        end
    end

    // ------------------------------------------------------------
    // integer divider bank select (no spread here)
    // ------------------------------------------------------------
    logic [INT_W-1:0] next_int_div;

    always_comb begin
        next_int_div = int_fs_sync ? int_div_b_i : int_div_a_i;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_div_o <= '0;
        end else if (clk_en_i) begin
            int_div_o <= next_int_div;
        end
    end

    // ------------------------------------------------------------
    // fractional dividers with spread
    // ------------------------------------------------------------
    function automatic logic mode_valid(input logic [1:0] m);
        mode_valid = (m == `FDSS_MODE_CENTER) || (m == `FDSS_MODE_DOWN);
    endfunction

    genvar d;
    generate
        for (d = 0; d < NUM_DIV; d++) begin : g_div
            // held copy of the active bank; only enable tracks live
            fdss_pkg::fdss_bank_t held, next_held;
            logic sel, next_sel;
            logic [`FDSS_CLK_NUM_W-1:0] clk_cnt, next_clk_cnt;
            logic [`FDSS_STEP_NUM_W:0] step_cnt, next_step_cnt;
            logic first_leg, next_first_leg;
            logic [`FDSS_STEP_NUM_W:0] leg_len;
            logic [`FDSS_STEP_RES_W-1:0] res_acc, next_res_acc;
            logic [`FDSS_OFFSET_W-1:0] offset, next_offset;
            fdss_pkg::fdss_dir_t dir, next_dir;
            logic run, next_on;
            fdss_pkg::fdss_bank_t src;
            logic [`FDSS_STEP_RES_W:0] res_sum;
            logic [`FDSS_OFFSET_W-1:0] inc;
            logic boundary;

            always_comb begin
                src = bank_cfg_i[2*d + int'(fs_sync[d])];
                run = held.ena && mode_valid(held.mode) && active_o;
                boundary = (clk_cnt == '0);
                // center starts at the mean, so only its first leg is a quarter;
                // every later leg runs extreme to extreme, a half period
                leg_len = first_leg ? {1'b0, held.step_num} : {held.step_num, 1'b0};
                next_first_leg = first_leg;
                next_held = held;
                next_held.ena = bank_cfg_i[2*d + int'(sel)].ena;
                next_sel = sel;
                next_clk_cnt = clk_cnt;
                next_step_cnt = step_cnt;
                next_res_acc = res_acc;
                next_offset = offset;
                next_dir = dir;
                res_sum = {1'b0, res_acc} + {1'b0, held.step_res};
                inc = {{(`FDSS_OFFSET_W-8){1'b0}}, held.step_intg};
                // bank swap waits for a step boundary at zero offset
                // so the period never jumps mid-cycle
                if (fs_sync[d] != sel && (boundary || !run) && offset == '0) begin
                    next_sel = fs_sync[d];
                    next_first_leg = (src.mode == `FDSS_MODE_CENTER);
                    next_held = src;
                    next_clk_cnt = '0;
                    next_step_cnt = '0;
                    next_res_acc = '0;
                    next_dir = (src.mode == `FDSS_MODE_DOWN) ?
                        fdss_pkg::FDSS_DIR_DOWN : fdss_pkg::FDSS_DIR_UP;
                end else if (!run) begin
                    next_clk_cnt = '0;
                    next_step_cnt = '0;
                    next_res_acc = '0;
                    next_offset = '0;
                    next_first_leg = (held.mode == `FDSS_MODE_CENTER);
                    next_dir = (held.mode == `FDSS_MODE_DOWN) ?
                        fdss_pkg::FDSS_DIR_DOWN : fdss_pkg::FDSS_DIR_UP;
                end else if (boundary) begin
                    next_clk_cnt = (held.clk_num == '0) ? '0 : held.clk_num - 8'h01;
                    if (res_sum >= {1'b0, held.step_den} && held.step_den != '0) begin
                        next_res_acc = res_sum[`FDSS_STEP_RES_W-1:0] - held.step_den;
                        inc = inc + 32'h00000001;
                    end else begin
                        next_res_acc = res_sum[`FDSS_STEP_RES_W-1:0];
                    end
                    next_offset = (dir == fdss_pkg::FDSS_DIR_UP) ? offset + inc
                        : offset - inc;
                    // leg done: turn around at the extreme
                    if (step_cnt + 13'h0001 >= leg_len) begin
                        next_step_cnt = '0;
                        next_first_leg = 1'b0;
                        next_dir = (dir == fdss_pkg::FDSS_DIR_UP) ?
                            fdss_pkg::FDSS_DIR_DOWN : fdss_pkg::FDSS_DIR_UP;
                    end else begin
                        next_step_cnt = step_cnt + 13'h0001;
                    end
                end else begin
                    next_clk_cnt = clk_cnt - 8'h01;
                end
                next_on = run;
            end

            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    held <= '0;
                    sel <= 1'b0;
                    clk_cnt <= '0;
                    step_cnt <= '0;
                    res_acc <= '0;
                    offset <= '0;
                    dir <= fdss_pkg::FDSS_DIR_UP;
                    first_leg <= 1'b0;
                    active_bank_o[d] <= 1'b0;
                    spread_on_o[d] <= 1'b0;
                    frac_offset_o[d] <= '0;
                end else if (clk_en_i) begin
                    held <= next_held;
                    sel <= next_sel;
                    clk_cnt <= next_clk_cnt;
                    step_cnt <= next_step_cnt;
                    res_acc <= next_res_acc;
                    offset <= next_offset;
                    dir <= next_dir;
                    first_leg <= next_first_leg;
                    active_bank_o[d] <= next_sel;
                    spread_on_o[d] <= next_on;
                    frac_offset_o[d] <= next_offset;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- fdss_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module fdss_top_sva #(
    parameter int NUM_DIV = 2,
    parameter int INT_W = 8
) (
    // clock, reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // watched inputs
    input wire logic clk_en_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [NUM_DIV-1:0] frequency_select_i,
    input wire logic int_frequency_select_i,
    input wire logic [INT_W-1:0] int_div_b_i,
    // watched outputs
    input wire logic [7:0] reg_rdata_o,
    input wire logic [NUM_DIV-1:0] active_bank_o,
    input wire logic [NUM_DIV-1:0] spread_on_o,
    input wire logic [31:0] frac_offset_o [NUM_DIV],
    input wire logic [INT_W-1:0] int_div_o,
    input wire logic active_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence cmd_wr(logic [7:0] c);
        clk_en_i && reg_wr_i && reg_addr_i == 8'h06 && reg_wdata_i == c;
    endsequence
    sequence fs_b_held;
        (clk_en_i && frequency_select_i[0] && frac_offset_o[0] == 0) [*6];
    endsequence
    a_enter_active: assert property (cmd_wr(8'h02) |=> active_o)
        else $error("ACTIVE command ignored");
    a_enter_ready: assert property (cmd_wr(8'h01) |=> !active_o)
        else $error("READY command ignored");
    a_other_code: assert property (clk_en_i && reg_wr_i && reg_addr_i == 8'h06
        && reg_wdata_i != 8'h01 && reg_wdata_i != 8'h02 |=> $stable(active_o))
        else $error("unknown command changed state");
    a_state_read: assert property (clk_en_i && !reg_wr_i && reg_addr_i == 8'h07
        |=> reg_rdata_o == (active_o ? 8'h02 : 8'h01))
        else $error("state read wrong");
    a_idle_no_spread: assert property (!active_o && !$past(active_o) |-> spread_on_o == '0)
        else $error("spread outside ACTIVE");
    a_off_no_offset: assert property (!spread_on_o[0] && !$past(spread_on_o[0])
        |-> frac_offset_o[0] == 0)
        else $error("offset while spread off");
    a_switch_at_zero: assert property ($changed(active_bank_o[0])
        |-> $past(frac_offset_o[0]) == 0)
        else $error("bank switched mid-excursion");
    a_bank_follows: assert property (fs_b_held |=> active_bank_o[0])
        else $error("bank B not taken");
    a_int_bank_b: assert property ((int_frequency_select_i && $stable(int_div_b_i)) [*5]
        |=> int_div_o == int_div_b_i)
        else $error("integer bank B not used");
    a_freeze_holds: assert property (!clk_en_i |=> $stable(frac_offset_o[0]))
        else $error("offset moved while frozen");
endmodule
bind fdss_top fdss_top_sva #(.NUM_DIV(NUM_DIV), .INT_W(INT_W)) u_sva (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .frequency_select_i(frequency_select_i),
    .int_frequency_select_i(int_frequency_select_i),
    .int_div_b_i(int_div_b_i),
    .reg_rdata_o(reg_rdata_o),
    .active_bank_o(active_bank_o),
    .spread_on_o(spread_on_o),
    .frac_offset_o(frac_offset_o),
    .int_div_o(int_div_o),
    .active_o(active_o)
);
`default_nettype wire

//--- fdss_host.sv
`timescale 1ns/10ps
`default_nettype none
module fdss_host (
    // clock
    input wire logic clk_i,
    // register port
    input wire logic [7:0] reg_rdata_i,
    output logic reg_wr_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    // ----------------------------------------
    // register access, one-cycle strobe
    // ----------------------------------------
    initial begin
        reg_wr_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        // stale data must not look valid
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_addr_o = a;
        @(posedge clk_i);
        #1;
        d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

//--- fdss_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module fdss_top_bench;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    logic clk_i, reset_n_i, clk_en_i, reg_wr_i, int_frequency_select_i, active_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, int_div_a_i, int_div_b_i, int_div_o, rd_d;
    logic [1:0] frequency_select_i, input_clk_ok_i, active_bank_o, spread_on_o;
    logic [31:0] frac_offset_o [2];
    fdss_pkg::fdss_bank_t bank_cfg_i [4];
    int errors, checks;
    fdss_top u_dut (.clk_i, .reset_n_i, .clk_en_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
        .reg_rdata_o, .bank_cfg_i, .frequency_select_i, .input_clk_ok_i, .int_frequency_select_i,
        .int_div_a_i, .int_div_b_i, .active_bank_o, .spread_on_o, .frac_offset_o, .int_div_o,
        .active_o);
    fdss_host u_host (.clk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
    task finish_test;
        if (errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // a fraction equal to its denominator carries on every step, one unit each;
    // mode 2 is never programmed, so that pass runs center with enable off
    task automatic run_mode(input logic [1:0] m, input int idx);
        int mx, mn, gap, nchg;
        logic [31:0] prev;
        // host-side sums behind these numbers
        bank_cfg_i[idx] = '{m != 2'h2, (m == 2'h2) ? 2'h1 : m, 8'h01, 12'h003,
            8'h00, 15'h7FFF, 15'h7FFF};
        bank_cfg_i[idx ^ 1].ena = 1'b0;
        repeat (4) @(posedge clk_i);
        #1 frequency_select_i[0] = idx[0];
        repeat (8) @(posedge clk_i);
        #1 chk(active_bank_o[0], idx[0]);
        chk(spread_on_o[0], m[0]);
        mx = 0;
        mn = 0;
        gap = 0;
        nchg = 0;
        prev = frac_offset_o[0];
        repeat (60) begin
            @(posedge clk_i);
            #1 gap++;
            if (frac_offset_o[0] !== prev) begin
                if (nchg > 0) chk(gap, 1);
                chk(frac_offset_o[0] - prev == 1 || prev - frac_offset_o[0] == 1, 1);
                nchg++;
                gap = 0;
            end
            if ($signed(frac_offset_o[0]) > mx) mx = $signed(frac_offset_o[0]);
            if ($signed(frac_offset_o[0]) < mn) mn = $signed(frac_offset_o[0]);
            prev = frac_offset_o[0];
            chk(frac_offset_o[1], 0);
        end
        chk(mx, (m == 2'h1) ? 3 : 0);
        chk(mn, (m == 2'h1) ? -3 : (m == 2'h3) ? -6 : 0);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        errors++;
        finish_test;
    end
    initial begin
        errors = 0;
        checks = 0;
        reset_n_i = 1'b0;
        clk_en_i = 1'b1;
        frequency_select_i = 2'h0;
        input_clk_ok_i = 2'h3;
        int_frequency_select_i = 1'b0;
        int_div_a_i = 8'h11;
        int_div_b_i = 8'h22;
        for (int i = 0; i < 4; i++) bank_cfg_i[i] = '0;
        repeat (6) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        chk(active_o, 0);
        u_host.rd(8'h06, rd_d);
        chk(rd_d, 8'h01);
        u_host.wr(8'h06, 8'h02);
        u_host.rd(8'h07, rd_d);
        chk(rd_d, 8'h02);
        u_host.wr(8'h06, 8'h05);
        u_host.rd(8'h06, rd_d);
        chk(rd_d, 8'h05);
        chk(active_o, 1);
        for (int m = 0; m < 4; m++) run_mode(m[1:0], (m % 2 == 0) ? 1 : 0);
        clk_en_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 clk_en_i = 1'b1;
        int_frequency_select_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 chk(int_div_o, 8'h22);
        int_frequency_select_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1 chk(int_div_o, 8'h11);
        u_host.wr(8'h06, 8'h01);
        u_host.rd(8'h07, rd_d);
        chk(rd_d, 8'h01);
        repeat (4) @(posedge clk_i);
        #1 chk(spread_on_o, 0);
        chk(frac_offset_o[0], 0);
        finish_test;
    end
endmodule
`default_nettype wire
